//--- design/qadser_pkg.sv
// shared constants and types for the quad channel serializer
package qadser_pkg;
	localparam int CHANNELS = 4;
	localparam int SAMPLE_BITS = 12;
	localparam int WIDE_BITS = 14;
	localparam int SEQ_BITS = 2 * WIDE_BITS;
	localparam int FIFO_DEPTH = 4;
	localparam int CONVERSION_LATENCY = 12;
	// timing, each figure in its own unit; global wake and clock stop converted to core cycles, channel wake kept in samples
	localparam int CORE_CLK_HZ = 40_000_000;
	localparam int GLOBAL_WAKE_US = 100;
	localparam int GLOBAL_WAKE_CYCLES = GLOBAL_WAKE_US * (CORE_CLK_HZ / 1_000_000);
	localparam int CLOCK_STOP_MIN_SPS = 1_000_000;
	localparam int CLOCK_STOP_CYCLES = CORE_CLK_HZ / CLOCK_STOP_MIN_SPS;
	localparam int CHANNEL_WAKE_SAMPLES = 200;
	localparam int WAKE_CNT_BITS = 12;
	localparam int CHAN_CNT_BITS = 8;
	// output codes
	localparam logic [11:0] CODE_POS_FULL_OB = 12'hFFF;
	localparam logic [11:0] CODE_NEG_FULL_OB = 12'h000;
	localparam logic [11:0] CODE_SIGN_FLIP = 12'h800;
	localparam logic [11:0] CODE_IDLE = 12'h000;
	// line drive level codes and currents in tenths of a milliamp
	localparam logic [1:0] DRIVE_3P5 = 2'h0;
	localparam logic [1:0] DRIVE_2P5 = 2'h1;
	localparam logic [1:0] DRIVE_3P0 = 2'h2;
	localparam logic [1:0] DRIVE_4P5 = 2'h3;
	localparam logic [6:0] CURR_3P5 = 7'h23;
	localparam logic [6:0] CURR_2P5 = 7'h19;
	localparam logic [6:0] CURR_3P0 = 7'h1E;
	localparam logic [6:0] CURR_4P5 = 7'h2D;
	localparam logic [4:0] TERM_RESET = 5'h00;

	typedef enum logic [1:0] {
		QADSER_BYTE_WISE,
		QADSER_BIT_WISE,
		QADSER_WORD_WISE
	} qadser_order_e;

	typedef struct packed {
		logic twoLane;
		logic ser14;
		logic sdrBitClk;
		qadser_order_e laneOrder;
		logic lsbFirst;
		logic offsetBinary;
	} qadser_cfg_s;

	typedef struct packed {
		logic [CHANNELS-1:0][SAMPLE_BITS-1:0] raw;
		logic [CHANNELS-1:0] overPos;
		logic [CHANNELS-1:0] overNeg;
	} qadser_sample_s;

	typedef logic [CHANNELS-1:0][SAMPLE_BITS-1:0] qadser_word_t;

	localparam qadser_cfg_s CFG_RESET = '0;
endpackage

//--- design/qadser_serializer.sv
// four channel sample serializer with power states and output fifo
// What this block does
// - global sleep kills drivers; valid after 100 us
// - per-channel standby; valid after 200 sample clocks
// - sample clock under 1 MSPS stops outputs
// - one lane: frame at sample rate, DDR
// - one lane per channel, word per frame, MSB first
// - two lane 12x sends 6 bits per lane
// - two lane 14x pads two zeros, 7 bits
// - 14x frame full rate SDR, half rate DDR
// - byte-wise: lane zero low, lane one high
// - bit-wise: lane zero even, lane one odd
// - word-wise alternates samples, half rate frame
// - MSB first default, LSB first reverses bit order in each lane
// - two's complement default, offset binary selectable
// - overdrive clamps to full scale codes
// - drive level 3.5 mA default, boost doubles
// - five termination enables, clock and data apart
// - latency is 12 samples plus serializer
`timescale 1ns/1ps
`default_nettype none

module qadser_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rstN,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr_reg, rdPtr_reg;
	logic [PW:0] count_reg;
	wire logic doWrite, doRead;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gChk
		$error("fifo depth must be a power of two of at least 2");
	end

	// honest flags straight from the occupancy count
	assign inReady = (count_reg != (PW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem[rdPtr_reg];
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (doWrite)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (doRead)
				rdPtr_reg <= rdPtr_reg + 1'b1;
			count_reg <= count_reg + (PW+1)'(doWrite) - (PW+1)'(doRead);
		end
	end

	// storage has no reset, it is only read behind a valid count
	always_ff @(posedge core_clk) begin
		if (doWrite)
			mem[wrPtr_reg] <= inData;
	end
endmodule

module qadser_serializer (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic sampleClk,
	input wire qadser_pkg::qadser_sample_s sampleIn,
	input wire logic global_sleep_bit,
	input wire logic [qadser_pkg::CHANNELS-1:0] channel_sleep_bits,
	input wire qadser_pkg::qadser_cfg_s cfgIn,
	input wire logic [1:0] line_drive_level,
	input wire logic drive_boost,
	input wire logic [4:0] termClkSel,
	input wire logic [4:0] termDataSel,
	output logic chan_a_lane_zero,
	output logic chan_b_lane_zero,
	output logic chan_c_lane_zero,
	output logic chan_d_lane_zero,
	output logic chan_a_lane_one,
	output logic chan_b_lane_one,
	output logic chan_c_lane_one,
	output logic chan_d_lane_one,
	output logic dataLaneOe,
	output logic bitClkOut,
	output logic frameClkOut,
	output logic clkLaneOe,
	output logic dataValid,
	output logic fifoOverrun,
	output logic [6:0] driveCurrentTenths,
	output logic [4:0] termClkEn,
	output logic [4:0] termDataEn
);
	import qadser_pkg::*;

	// clamp and recode one sample
	function automatic logic [11:0] formatCode(logic [11:0] raw, logic pos,
			logic neg, logic offsetBin);
		logic [11:0] ob;
		ob = pos ? CODE_POS_FULL_OB : (neg ? CODE_NEG_FULL_OB : raw);
		return offsetBin ? ob : (ob ^ CODE_SIGN_FLIP);
	endfunction

	// one lane's bits, MSB of the result sent first
	function automatic logic [WIDE_BITS-1:0] laneBits(logic [13:0] ext,
			int n, int sel, logic lsbFirst);
		logic [WIDE_BITS-1:0] seq;
		int p;
		seq = '0;
		for (int k = 0; k < WIDE_BITS; k++) begin
			p = lsbFirst ? k : n - 1 - k;
			if (k < n) begin
				unique case (sel)
					0: seq[WIDE_BITS-1-k] = ext[p];
					1: seq[WIDE_BITS-1-k] = ext[(p + n) % WIDE_BITS];
					2: seq[WIDE_BITS-1-k] = ext[(2 * p) % WIDE_BITS];
					3: seq[WIDE_BITS-1-k] = ext[(2 * p + 1) % WIDE_BITS];
					default: seq[WIDE_BITS-1-k] = ext[p];
				endcase
			end
		end
		return seq;
	endfunction

	// bits per lane per sample
	function automatic int laneWidth(qadser_cfg_s c);
		int w;
		w = c.ser14 ? WIDE_BITS : SAMPLE_BITS;
		if (c.twoLane && c.laneOrder != QADSER_WORD_WISE)
			w = w / 2;
		return w;
	endfunction

	// two samples per frame: two lane word-wise, or 14x two lane with DDR clock
	function automatic logic pairFrame(qadser_cfg_s c);
		return c.twoLane && (c.laneOrder == QADSER_WORD_WISE ||
			(c.ser14 && !c.sdrBitClk));
	endfunction

	function automatic logic [4:0] frameLen(qadser_cfg_s c);
		int len;
		len = laneWidth(c);
		if (pairFrame(c) && c.laneOrder != QADSER_WORD_WISE)
			len = 2 * len;
		return 5'(len);
	endfunction

	function automatic logic [6:0] driveOf(logic [1:0] lvl, logic boost);
		logic [6:0] base;
		unique case (lvl)
			DRIVE_3P5: base = CURR_3P5;
			DRIVE_2P5: base = CURR_2P5;
			DRIVE_3P0: base = CURR_3P0;
			DRIVE_4P5: base = CURR_4P5;
		endcase
		return boost ? 7'(base << 1) : base;
	endfunction

	logic rstMeta_reg, rstN;
	logic [2:0] sclkSync_reg;
	qadser_sample_s sampMeta_reg, sampSync_reg;
	qadser_cfg_s cfgMeta_reg, cfgSync_reg, cfgActive_reg;
	logic [1+CHANNELS+2+1+10-1:0] ctlMeta_reg, ctlSync_reg;
	qadser_sample_s pipe [CONVERSION_LATENCY];
	logic [WAKE_CNT_BITS-1:0] wakeCnt_reg, gapCnt_reg;
	logic [CHAN_CNT_BITS-1:0] chanCnt_reg [CHANNELS];
	logic [SEQ_BITS-1:0] lane0_reg [CHANNELS];
	logic [SEQ_BITS-1:0] lane1_reg [CHANNELS];
	logic [4:0] slotCnt_reg;
	logic phase_reg, haveA_reg, frameFull_reg;
	qadser_word_t holdA_reg;

	wire logic gSleep, sampleEdge, clockStopped, driversOn, awake;
	wire logic [CHANNELS-1:0] chSleep, chanOk;
	wire qadser_word_t fmtWord, fifoOut;
	wire logic fifoInReady, fifoOutValid, fifoPop;
	wire logic slotEn, frameEnd, needPair, takeA, loadPair, loadOne;
	wire logic [4:0] curLen;
	wire qadser_word_t wordA, wordB;
	wire logic [SEQ_BITS-1:0] nextLane0 [CHANNELS];
	wire logic [SEQ_BITS-1:0] nextLane1 [CHANNELS];

	// reset release through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_reg <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstN <= rstMeta_reg;
		end
	end

	// pins from outside the core clock all pass two flops first
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			sclkSync_reg <= '0;
			sampMeta_reg <= '0;
			sampSync_reg <= '0;
			cfgMeta_reg <= CFG_RESET;
			cfgSync_reg <= CFG_RESET;
			ctlMeta_reg <= {1'b1, {CHANNELS{1'b0}}, DRIVE_3P5, 1'b0, 10'h000};
			ctlSync_reg <= {1'b1, {CHANNELS{1'b0}}, DRIVE_3P5, 1'b0, 10'h000};
		end else begin
			sclkSync_reg <= {sclkSync_reg[1:0], sampleClk};
			sampMeta_reg <= sampleIn;
			sampSync_reg <= sampMeta_reg;
			cfgMeta_reg <= cfgIn;
			cfgSync_reg <= cfgMeta_reg;
			ctlMeta_reg <= {global_sleep_bit, channel_sleep_bits,
				line_drive_level, drive_boost, termClkSel, termDataSel};
			ctlSync_reg <= ctlMeta_reg;
		end
	end

	// decoded control and power state
	assign gSleep = ctlSync_reg[17];
	assign chSleep = ctlSync_reg[16:13];
	assign sampleEdge = sclkSync_reg[1] && !sclkSync_reg[2];
	assign clockStopped = (gapCnt_reg == WAKE_CNT_BITS'(CLOCK_STOP_CYCLES));
	assign driversOn = !gSleep && !clockStopped;
	assign awake = (wakeCnt_reg == WAKE_CNT_BITS'(GLOBAL_WAKE_CYCLES));

	// wake timers: global and clock stop in core cycles, standby in samples
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			wakeCnt_reg <= '0;
			gapCnt_reg <= '0;
		end else begin
			if (sampleEdge)
				gapCnt_reg <= '0;
			else if (!clockStopped)
				gapCnt_reg <= gapCnt_reg + 1'b1;
			if (!driversOn)
				wakeCnt_reg <= '0;
			else if (!awake)
				wakeCnt_reg <= wakeCnt_reg + 1'b1;
		end
	end

	for (genvar c = 0; c < CHANNELS; c++) begin : gChan
		assign chanOk[c] = (chanCnt_reg[c] == CHAN_CNT_BITS'(CHANNEL_WAKE_SAMPLES));
		// a sleeping channel sends idle code, drivers stay up
		assign fmtWord[c] = chanOk[c] ? formatCode(pipe[CONVERSION_LATENCY-1].raw[c],
			pipe[CONVERSION_LATENCY-1].overPos[c],
			pipe[CONVERSION_LATENCY-1].overNeg[c],
			cfgSync_reg.offsetBinary) : CODE_IDLE;
		always_ff @(posedge core_clk or negedge rstN) begin
			if (!rstN)
				chanCnt_reg[c] <= '0;
			else if (chSleep[c] || !driversOn)
				chanCnt_reg[c] <= '0;
			else if (sampleEdge && !chanOk[c])
				chanCnt_reg[c] <= chanCnt_reg[c] + 1'b1;
		end
	end

	// conversion latency: twelve sample clocks before the fifo
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < CONVERSION_LATENCY; i++)
				pipe[i] <= '0;
		end else if (sampleEdge) begin
			pipe[0] <= sampSync_reg;
			for (int i = 1; i < CONVERSION_LATENCY; i++)
				pipe[i] <= pipe[i-1];
		end
	end

	qadser_fifo #(
		.WIDTH($bits(qadser_word_t)),
		.DEPTH(FIFO_DEPTH)
	) uFifo (
		.core_clk(core_clk),
		.rstN(rstN),
		.inData(fmtWord),
		.inValid(sampleEdge),
		.inReady(fifoInReady),
		.outData(fifoOut),
		.outValid(fifoOutValid),
		.outReady(fifoPop)
	);

	// frame timing; SDR advances a slot every other core cycle
	assign curLen = frameLen(cfgActive_reg);
	assign slotEn = !cfgActive_reg.sdrBitClk || phase_reg;
	assign frameEnd = slotEn && (slotCnt_reg == curLen - 5'h01);
	// next frame's words, judged by the settings it will use
	assign needPair = pairFrame(cfgSync_reg);
	assign takeA = needPair && !haveA_reg && fifoOutValid;
	assign loadPair = frameEnd && needPair && haveA_reg && fifoOutValid;
	assign loadOne = frameEnd && !needPair && (haveA_reg || fifoOutValid);
	assign fifoPop = takeA || loadPair || (loadOne && !haveA_reg);
	assign wordA = haveA_reg ? holdA_reg : fifoOut;
	assign wordB = fifoOut;

	for (genvar c = 0; c < CHANNELS; c++) begin : gLane
		wire logic [13:0] extA = {2'b00, wordA[c]};
		wire logic [13:0] extB = {2'b00, wordB[c]};
		wire integer n = laneWidth(cfgSync_reg);
		wire logic ls = cfgSync_reg.lsbFirst;
		wire logic word = cfgSync_reg.laneOrder == QADSER_WORD_WISE;
		wire integer s0 = (cfgSync_reg.laneOrder == QADSER_BIT_WISE) ? 2 : 0;
		wire integer s1 = s0 + 1;
		wire logic [WIDE_BITS-1:0] a0 = laneBits(extA, n, word ? 4 : s0, ls);
		wire logic [WIDE_BITS-1:0] a1 = laneBits(extA, n, s1, ls);
		wire logic [WIDE_BITS-1:0] b0 = laneBits(extB, n, s0, ls);
		wire logic [WIDE_BITS-1:0] b1 = laneBits(extB, n, s1, ls);
		wire logic [WIDE_BITS-1:0] bw = laneBits(extB, n, 4, ls);
		wire logic seqPair = needPair && !word;
		// second sample of a half-rate frame other than word-wise follows the first on each lane
		assign nextLane0[c] = seqPair ? ({a0, 14'h0000} | ({b0, 14'h0000} >> n))
			: {a0, 14'h0000};
		assign nextLane1[c] = !cfgSync_reg.twoLane ? '0
			: word ? {bw, 14'h0000}
			: seqPair ? ({a1, 14'h0000} | ({b1, 14'h0000} >> n))
			: {a1, 14'h0000};
	end

	// shift lanes; new settings and words only at a frame boundary
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			cfgActive_reg <= CFG_RESET;
			slotCnt_reg <= '0;
			phase_reg <= 1'b0;
			haveA_reg <= 1'b0;
			holdA_reg <= '0;
			frameFull_reg <= 1'b0;
			for (int c = 0; c < CHANNELS; c++) begin
				lane0_reg[c] <= '0;
				lane1_reg[c] <= '0;
			end
		end else begin
			phase_reg <= cfgActive_reg.sdrBitClk ? !phase_reg : 1'b0;
			if (takeA) begin
				holdA_reg <= fifoOut;
				haveA_reg <= 1'b1;
			end
			if (frameEnd) begin
				cfgActive_reg <= cfgSync_reg;
				slotCnt_reg <= '0;
				phase_reg <= 1'b0;
				frameFull_reg <= loadPair || loadOne;
				if (loadPair || (loadOne && haveA_reg))
					haveA_reg <= 1'b0;
				for (int c = 0; c < CHANNELS; c++) begin
					lane0_reg[c] <= (loadPair || loadOne) ? nextLane0[c] : '0;
					lane1_reg[c] <= (loadPair || loadOne) ? nextLane1[c] : '0;
				end
			end else if (slotEn) begin
				slotCnt_reg <= slotCnt_reg + 5'h01;
				for (int c = 0; c < CHANNELS; c++) begin
					lane0_reg[c] <= {lane0_reg[c][SEQ_BITS-2:0], 1'b0};
					lane1_reg[c] <= {lane1_reg[c][SEQ_BITS-2:0], 1'b0};
				end
			end
		end
	end

	// clock lanes and status, all registered
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			bitClkOut <= 1'b0;
			frameClkOut <= 1'b0;
			dataLaneOe <= 1'b0;
			clkLaneOe <= 1'b0;
			dataValid <= 1'b0;
			fifoOverrun <= 1'b0;
			driveCurrentTenths <= CURR_3P5;
			termClkEn <= TERM_RESET;
			termDataEn <= TERM_RESET;
		end else begin
			// DDR: one bit per clock edge; SDR: rising edge per bit
			if (frameEnd)
				bitClkOut <= 1'b1;
			else if (cfgActive_reg.sdrBitClk)
				bitClkOut <= phase_reg;
			else if (slotEn)
				bitClkOut <= !bitClkOut;
			// frame clock high over first half, rising at word start
			if (frameEnd)
				frameClkOut <= 1'b1;
			else if (slotEn)
				frameClkOut <= (slotCnt_reg + 5'h01) < (curLen >> 1);
			dataLaneOe <= driversOn;
			clkLaneOe <= driversOn;
			dataValid <= driversOn && awake && frameFull_reg;
			// sample clock cannot stall, so a full fifo loses the sample
			fifoOverrun <= fifoOverrun || (sampleEdge && !fifoInReady);
			driveCurrentTenths <= driveOf(ctlSync_reg[12:11], ctlSync_reg[10]);
			termClkEn <= ctlSync_reg[9:5];
			termDataEn <= ctlSync_reg[4:0];
		end
	end

	assign chan_a_lane_zero = lane0_reg[0][SEQ_BITS-1];
	assign chan_b_lane_zero = lane0_reg[1][SEQ_BITS-1];
	assign chan_c_lane_zero = lane0_reg[2][SEQ_BITS-1];
	assign chan_d_lane_zero = lane0_reg[3][SEQ_BITS-1];
	assign chan_a_lane_one = lane1_reg[0][SEQ_BITS-1];
	assign chan_b_lane_one = lane1_reg[1][SEQ_BITS-1];
	assign chan_c_lane_one = lane1_reg[2][SEQ_BITS-1];
	assign chan_d_lane_one = lane1_reg[3][SEQ_BITS-1];
endmodule

`default_nettype wire

//--- sim/qadser_serializer_properties.sv
// port level checks on the quad channel serializer
`timescale 1ns/1ps
`default_nettype none
module qadser_serializer_properties (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic sampleClk,
	input wire logic global_sleep_bit,
	input wire logic [qadser_pkg::CHANNELS-1:0] channel_sleep_bits,
	input wire qadser_pkg::qadser_cfg_s cfgIn,
	input wire logic [1:0] line_drive_level,
	input wire logic drive_boost,
	input wire logic [4:0] termClkSel,
	input wire logic [4:0] termDataSel,
	input wire logic dataLaneOe,
	input wire logic bitClkOut,
	input wire logic frameClkOut,
	input wire logic clkLaneOe,
	input wire logic dataValid,
	input wire logic fifoOverrun,
	input wire logic [6:0] driveCurrentTenths,
	input wire logic [4:0] termClkEn,
	input wire logic [4:0] termDataEn
);
	import qadser_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [12:0] oeCnt;
	logic [7:0] stillCnt;
	logic [5:0] cfgAge;
	logic clkPrev;
	qadser_cfg_s cfgPrev;
	logic [6:0] currBase, currExp;
	// expected drive current from the level code and boost
	assign currBase = (line_drive_level == DRIVE_2P5) ? CURR_2P5 :
		(line_drive_level == DRIVE_3P0) ? CURR_3P0 :
		(line_drive_level == DRIVE_4P5) ? CURR_4P5 : CURR_3P5;
	assign currExp = drive_boost ? 7'(currBase << 1) : currBase;
	// saturating ages: drivers on, sample clock still, config unchanged
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			oeCnt <= 13'h0000;
			stillCnt <= 8'h00;
			cfgAge <= 6'h00;
			clkPrev <= 1'b0;
			cfgPrev <= CFG_RESET;
		end else begin
			oeCnt <= !dataLaneOe ? 13'h0000 : oeCnt + 13'(oeCnt != 13'h1FFF);
			stillCnt <= (sampleClk != clkPrev) ? 8'h00 :
				stillCnt + 8'(stillCnt != 8'hFF);
			cfgAge <= (cfgIn != cfgPrev) ? 6'h00 : cfgAge + 6'(cfgAge != 6'h3F);
			clkPrev <= sampleClk;
			cfgPrev <= cfgIn;
		end
	end
	property p_sleep_off;
		global_sleep_bit [*5] |-> !dataLaneOe && !clkLaneOe;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("drivers on in global sleep");
	property p_wake;
		dataValid |-> oeCnt >= 13'(GLOBAL_WAKE_CYCLES - 2);
	endproperty
	a_wake: assert property (p_wake)
		else $error("data valid before wake time");
	property p_valid_oe;
		dataValid |-> dataLaneOe && clkLaneOe;
	endproperty
	a_valid_oe: assert property (p_valid_oe)
		else $error("data valid with drivers off");
	property p_clock_stop;
		stillCnt > 8'(CLOCK_STOP_CYCLES + 10) |-> !dataLaneOe;
	endproperty
	a_clock_stop: assert property (p_clock_stop)
		else $error("drivers on with sample clock stopped");
	property p_standby_oe;
		$rose(|channel_sleep_bits) && dataLaneOe && !global_sleep_bit
			|=> dataLaneOe [*8];
	endproperty
	a_standby_oe: assert property (p_standby_oe)
		else $error("drivers dropped in channel standby");
	property p_frame_start;
		$rose(frameClkOut) |-> bitClkOut ##1 frameClkOut [*2];
	endproperty
	a_frame_start: assert property (p_frame_start)
		else $error("frame start without bit clock rise");
	property p_ddr_toggle;
		cfgAge == 6'h3F && cfgIn.twoLane && !cfgIn.sdrBitClk && !cfgIn.ser14
			&& frameClkOut && $past(frameClkOut)
			|-> bitClkOut != $past(bitClkOut);
	endproperty
	a_ddr_toggle: assert property (p_ddr_toggle)
		else $error("bit clock not toggling per slot");
	property p_drive;
		($stable(line_drive_level) && $stable(drive_boost)) [*8]
			|-> driveCurrentTenths == currExp;
	endproperty
	a_drive: assert property (p_drive)
		else $error("drive current mismatch");
	property p_term;
		($stable(termClkSel) && $stable(termDataSel)) [*8]
			|-> termClkEn == termClkSel && termDataEn == termDataSel;
	endproperty
	a_term: assert property (p_term)
		else $error("termination enables mismatch");
	c_frame: cover property ($rose(frameClkOut) && dataValid);
	c_overrun: cover property ($rose(fifoOverrun));
	c_wake: cover property ($rose(dataLaneOe));
endmodule
bind qadser_serializer qadser_serializer_properties props (
	.core_clk(core_clk),
	.reset_n(reset_n),
	.sampleClk(sampleClk),
	.global_sleep_bit(global_sleep_bit),
	.channel_sleep_bits(channel_sleep_bits),
	.cfgIn(cfgIn),
	.line_drive_level(line_drive_level),
	.drive_boost(drive_boost),
	.termClkSel(termClkSel),
	.termDataSel(termDataSel),
	.dataLaneOe(dataLaneOe),
	.bitClkOut(bitClkOut),
	.frameClkOut(frameClkOut),
	.clkLaneOe(clkLaneOe),
	.dataValid(dataValid),
	.fifoOverrun(fifoOverrun),
	.driveCurrentTenths(driveCurrentTenths),
	.termClkEn(termClkEn),
	.termDataEn(termDataEn)
);
`default_nettype wire

//--- sim/qadser_rx_model.sv
// deserializing receiver that rebuilds each channel's word
`timescale 1ns/1ps
`default_nettype none
module qadser_rx_model (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [3:0] laneZero,
	input wire logic [3:0] laneOne,
	input wire logic frameClk,
	input wire logic validIn,
	input wire qadser_pkg::qadser_cfg_s cfg,
	output qadser_pkg::qadser_word_t rxWord
);
	import qadser_pkg::*;
	logic [3:0][11:0] sh0, sh1;
	logic frPrev;
	int slot, lastSlot;
	// word-wise frames carry a whole sample per lane
	assign lastSlot = (cfg.laneOrder == QADSER_WORD_WISE) ? 11 : 5;
	// a holds lane zero bits, b lane one, last arrival at bit 0
	function automatic logic [11:0] build(input qadser_cfg_s k,
			input logic [11:0] a, input logic [11:0] b);
		logic [5:0] p, q;
		logic [11:0] w;
		p = a[5:0];
		q = b[5:0];
		if (k.lsbFirst) begin
			p = {<<{p}};
			q = {<<{q}};
		end
		w = {q, p};
		if (k.laneOrder == QADSER_BIT_WISE) begin
			for (int i = 0; i < 6; i++) begin
				w[2*i] = p[i];
				w[2*i+1] = q[i];
			end
		end
		if (k.laneOrder == QADSER_WORD_WISE) begin
			w = k.lsbFirst ? {<<{a}} : a;
		end
		return w;
	endfunction
	// frame rise marks slot zero; valid lags one cycle, judged at the last slot
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxWord <= '0;
			slot <= 99;
			frPrev <= 1'b0;
		end else begin
			frPrev <= frameClk;
			if (frameClk && !frPrev) begin
				slot <= 1;
			end else if (slot <= lastSlot) begin
				slot <= slot + 1;
			end
			for (int c = 0; c < 4; c++) begin
				sh0[c] <= {sh0[c][10:0], laneZero[c]};
				sh1[c] <= {sh1[c][10:0], laneOne[c]};
				if (slot == lastSlot && validIn) begin
					rxWord[c] <= build(cfg, {sh0[c][10:0], laneZero[c]},
						{sh1[c][10:0], laneOne[c]});
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/test_qadser_serializer.sv
// self-checking bench for the quad channel serializer
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(what, exp, got) begin \
	numChecks++; \
	if ((got) !== (exp)) begin \
		errTotal++; \
		$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
	end \
end
module test_qadser_serializer;
	import qadser_pkg::*;
	localparam logic [6:0] CURR_T [4] = '{CURR_3P5, CURR_2P5, CURR_3P0, CURR_4P5};
	logic core_clk, reset_n, sampleClk, sampleRun, global_sleep_bit;
	logic drive_boost, dataLaneOe, bitClkOut, frameClkOut, clkLaneOe;
	logic dataValid, fifoOverrun;
	logic [3:0] channel_sleep_bits, laneZero, laneOne;
	logic [1:0] line_drive_level;
	logic [4:0] termClkSel, termDataSel, termClkEn, termDataEn;
	logic [6:0] driveCurrentTenths;
	qadser_sample_s sampleIn;
	qadser_cfg_s cfgIn, k;
	qadser_word_t rxWord;
	int errTotal = 0, numChecks = 0, cycles = 0, n;
	qadser_serializer dut (.core_clk(core_clk), .reset_n(reset_n),
		.sampleClk(sampleClk), .sampleIn(sampleIn),
		.global_sleep_bit(global_sleep_bit),
		.channel_sleep_bits(channel_sleep_bits), .cfgIn(cfgIn),
		.line_drive_level(line_drive_level), .drive_boost(drive_boost),
		.termClkSel(termClkSel), .termDataSel(termDataSel),
		.chan_a_lane_zero(laneZero[0]), .chan_b_lane_zero(laneZero[1]),
		.chan_c_lane_zero(laneZero[2]), .chan_d_lane_zero(laneZero[3]),
		.chan_a_lane_one(laneOne[0]), .chan_b_lane_one(laneOne[1]),
		.chan_c_lane_one(laneOne[2]), .chan_d_lane_one(laneOne[3]),
		.dataLaneOe(dataLaneOe), .bitClkOut(bitClkOut),
		.frameClkOut(frameClkOut), .clkLaneOe(clkLaneOe),
		.dataValid(dataValid), .fifoOverrun(fifoOverrun),
		.driveCurrentTenths(driveCurrentTenths),
		.termClkEn(termClkEn), .termDataEn(termDataEn));
	qadser_rx_model rx (.core_clk(core_clk), .reset_n(reset_n),
		.laneZero(laneZero), .laneOne(laneOne), .frameClk(frameClkOut),
		.validIn(dataValid), .cfg(cfgIn), .rxWord(rxWord));
	// core clock at 40 MHz; sample clock 200 ns, phase unrelated, gateable
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		sampleClk = 1'b0;
		#37;
		forever begin
			#100;
			if (sampleRun) sampleClk = ~sampleClk;
		end
	end
	// hang guard well above the expected run of about 17000 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			errTotal++;
			$display("timeout after %0d cycles", cycles);
			reportAndStop();
		end
	end
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic tick(input int t);
		repeat (t) @(posedge core_clk);
	endtask
	task automatic waitValid(output int w);
		w = 0;
		while (dataValid !== 1'b1 && w < 6000) begin
			@(posedge core_clk);
			w++;
		end
	endtask
	function automatic logic [11:0] expCode(input logic ob,
			input logic [11:0] raw, input logic op, input logic on);
		logic [11:0] c;
		c = op ? CODE_POS_FULL_OB : (on ? CODE_NEG_FULL_OB : raw);
		return ob ? c : c ^ CODE_SIGN_FLIP;
	endfunction
	// sample inputs change just after a sample clock fall, far from the rise
	task automatic runCase(input string name, input qadser_cfg_s cf,
			input logic [11:0] base, input logic [3:0] op, input logic [3:0] on);
		logic [11:0] e;
		@(negedge sampleClk);
		@(posedge core_clk);
		cfgIn <= cf;
		for (int c = 0; c < CHANNELS; c++) sampleIn.raw[c] <= base ^ 12'(c * 273);
		sampleIn.overPos <= op;
		sampleIn.overNeg <= on;
		tick(30 * 8); // latency plus several frames
		for (int c = 0; c < CHANNELS; c++) begin
			e = channel_sleep_bits[c] ? CODE_IDLE :
				expCode(cf.offsetBinary, base ^ 12'(c * 273), op[c], on[c]);
			`CHECK_EQ(name, e, rxWord[c])
		end
		$display("test %s done", name);
	endtask
	initial begin
		reset_n = 1'b0;
		sampleRun = 1'b1;
		global_sleep_bit = 1'b0;
		channel_sleep_bits = 4'h0;
		k = CFG_RESET;
		k.twoLane = 1'b1;
		cfgIn = k;
		sampleIn = '0;
		line_drive_level = DRIVE_3P5;
		drive_boost = 1'b0;
		termClkSel = 5'h00;
		termDataSel = 5'h00;
		tick(6);
		`CHECK_EQ("reset_oe", 1'b0, dataLaneOe)
		reset_n <= 1'b1;
		tick(3);
		`CHECK_EQ("reset_curr", CURR_3P5, driveCurrentTenths)
		`CHECK_EQ("reset_term", TERM_RESET, termClkEn)
		waitValid(n);
		`CHECK_EQ("powerup", 1'b1, n >= GLOBAL_WAKE_CYCLES - 10 && n < 4200)
		runCase("byte_msb_tc", k, 12'h5A3, 4'h0, 4'h0);
		k.laneOrder = QADSER_BIT_WISE;
		runCase("bit_msb_tc", k, 12'h9C6, 4'h0, 4'h0);
		k.lsbFirst = 1'b1;
		k.offsetBinary = 1'b1;
		runCase("bit_lsb_ob", k, 12'h3E1, 4'h0, 4'h0);
		k.laneOrder = QADSER_BYTE_WISE;
		runCase("byte_lsb_ob", k, 12'hB74, 4'h0, 4'h0);
		runCase("clamp_ob", k, 12'h456, 4'h1, 4'h2);
		k.lsbFirst = 1'b0;
		k.offsetBinary = 1'b0;
		runCase("clamp_tc", k, 12'h456, 4'h1, 4'h2);
		k.laneOrder = QADSER_WORD_WISE;
		runCase("word_msb_tc", k, 12'hA5C, 4'h0, 4'h0);
		// the idle code skips the recoding, so an idle channel reads zero in either format
		k.laneOrder = QADSER_BYTE_WISE;
		k.offsetBinary = 1'b1;
		channel_sleep_bits <= 4'h5;
		runCase("standby", k, 12'h2D9, 4'h0, 4'h0);
		`CHECK_EQ("standby_oe", 1'b1, dataLaneOe)
		channel_sleep_bits <= 4'h0;
		tick(100 * 8);
		`CHECK_EQ("waking", CODE_IDLE, rxWord[0])
		tick(140 * 8);
		`CHECK_EQ("awake", expCode(1'b1, 12'h2D9, 1'b0, 1'b0), rxWord[0])
		global_sleep_bit <= 1'b1;
		tick(10);
		`CHECK_EQ("sleep_oe", 3'h0, {dataLaneOe, clkLaneOe, dataValid})
		global_sleep_bit <= 1'b0;
		waitValid(n);
		`CHECK_EQ("sleep_wake", 1'b1, n >= GLOBAL_WAKE_CYCLES && n < 4200)
		sampleRun <= 1'b0;
		tick(CLOCK_STOP_CYCLES + 20);
		`CHECK_EQ("stop_oe", 2'h0, {dataLaneOe, clkLaneOe})
		sampleRun <= 1'b1;
		waitValid(n);
		`CHECK_EQ("stop_wake", 1'b1, n >= GLOBAL_WAKE_CYCLES && n < 4200)
		for (int i = 0; i < 8; i++) begin
			line_drive_level <= 2'(i);
			drive_boost <= i[2];
			termClkSel <= 5'(i * 5 + 1);
			termDataSel <= 5'(31 - i * 3);
			tick(8);
			`CHECK_EQ("drive", 7'(CURR_T[i % 4] << i[2]), driveCurrentTenths)
			`CHECK_EQ("term", {5'(i * 5 + 1), 5'(31 - i * 3)}, {termClkEn, termDataEn})
		end
		line_drive_level <= DRIVE_3P5;
		drive_boost <= 1'b0;
		$display("test drive_term done");
		// one lane needs 12 slots, longer than the 8 cycle sample period
		k.twoLane = 1'b0;
		cfgIn <= k;
		tick(100 * 8);
		`CHECK_EQ("overrun", 1'b1, fifoOverrun)
		reset_n <= 1'b0;
		tick(6);
		`CHECK_EQ("overrun_clear", 2'h0, {fifoOverrun, dataValid})
		reset_n <= 1'b1;
		tick(8);
		$display("test overrun done");
		reportAndStop();
	end
endmodule
`default_nettype wire
